/* gpic_pkg.sv */
// package: register map, field layout and codes of the global pin and irq control block
package gpic_pkg;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [8:0] GPIC_OFF_PIN_FUNC   = 9'h00A;
  localparam logic [8:0] GPIC_OFF_SUM_STATUS = 9'h010;
  localparam logic [8:0] GPIC_OFF_SUM_ENABLE = 9'h012;
  localparam logic [8:0] GPIC_OFF_REF_CLK    = 9'h004;
  localparam logic [8:0] GPIC_OFF_GLB_CTRL   = 9'h002;
  localparam logic [8:0] GPIC_OFF_PIN_READ   = 9'h01C;

  // ****************************************
  // field positions
  // ****************************************
  localparam int GPIC_BIT_REF_OUT_SEL = 9;
  localparam int GPIC_BIT_REF_IN_SEL  = 8;
  localparam int GPIC_BIT_IRQ_IDLE    = 14;
  localparam int GPIC_BIT_ERR_SRC     = 6;
  localparam int GPIC_LSB_PERF_MODE   = 4;
  localparam int GPIC_LSB_PORT_SUM    = 4;
  localparam int GPIC_BIT_TX_SUM      = 1;
  localparam int GPIC_BIT_GLB_SUM     = 0;

  // ****************************************
  // reset values and masks
  // ****************************************
  localparam logic [15:0] GPIC_RST_PIN_FUNC   = 16'h0000;
  localparam logic [15:0] GPIC_RST_SUM_ENABLE = 16'h0000;
  localparam logic [15:0] GPIC_RST_REF_CLK    = 16'h0000;
  localparam logic [15:0] GPIC_RST_GLB_CTRL   = 16'h0000;
  localparam logic [15:0] GPIC_MSK_SUM        = 16'h00F3;
  localparam logic [15:0] GPIC_MSK_REF_CLK    = 16'h1F0F;
  localparam logic [15:0] GPIC_MSK_GLB_CTRL   = 16'h4070;

  // ****************************************
  // codes
  // ****************************************
  typedef enum logic [1:0] {
    GPIC_FN_INPUT  = 2'h0,
    GPIC_FN_STATUS = 2'h1,
    GPIC_FN_LOW    = 2'h2,
    GPIC_FN_HIGH   = 2'h3
  } gpic_pin_fn_t;

  typedef enum logic [1:0] {
    GPIC_RATE_ALL   = 2'h0,
    GPIC_RATE_DS3   = 2'h1,
    GPIC_RATE_E3    = 2'h2,
    GPIC_RATE_STS1  = 2'h3
  } gpic_rate_t;

  localparam logic [1:0] GPIC_PM_PIN8 = 2'h1;

endpackage

/* gpic_pin_cell.sv */
// one general pin: function decode into output value and enable
`timescale 1ns/1ps
module gpic_pin_cell
  import gpic_pkg::*;
(
  // control
  input  wire logic [1:0] function_sel,
  input  wire logic       override,
  input  wire logic       override_val,
  input  wire logic       override_drive,
  // sources
  input  wire logic       status_sig,
  // pin
  output logic            pinOut,
  output logic            pinOe_n
);

  wire logic fnDrive = (function_sel != GPIC_FN_INPUT);
  wire logic fnVal   = (function_sel == GPIC_FN_STATUS) ? status_sig :
                       (function_sel == GPIC_FN_HIGH);

  assign pinOut  = override ? override_val : fnVal;
  assign pinOe_n = override ? ~override_drive : ~fnDrive;

endmodule // gpic_pin_cell

/* gpic_top.sv */
// global pin function, rate clock pin and interrupt summary control
`timescale 1ns/1ps
module gpic_top
  import gpic_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // register port
  input  wire logic [8:0]  regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [15:0] regRdData,
  // general pins
  input  wire logic [7:0]  gpPinIn,
  output logic      [7:0]  gpPinOut,
  output logic      [7:0]  gpPinOe_n,
  // rate clock pins
  input  wire logic        rate_clock_pin_a_in,
  input  wire logic        rate_clock_pin_b_in,
  input  wire logic        rate_clock_pin_c_in,
  output logic             rate_clock_pin_b_out,
  output logic             rate_clock_pin_b_oe_n,
  output logic             rate_clock_pin_c_out,
  output logic             rate_clock_pin_c_oe_n,
  // internal rate clocks
  input  wire logic        ds3Clk,
  input  wire logic        e3Clk,
  input  wire logic        sts1Clk,
  output logic             ds3ClkIn,
  output logic             e3ClkIn,
  output logic             sts1ClkIn,
  // 8 kHz reference
  input  wire logic        global_ref_out,
  output logic             global_ref_in,
  // per-port status and summary sources
  input  wire logic [3:0]  portStatusA,
  input  wire logic [3:0]  portStatusB,
  input  wire logic [3:0]  portIrqPending,
  input  wire logic        txIfacePending,
  input  wire logic        globalLatchedPending,
  // special pin functions
  input  wire logic        perfUpdateSw,
  input  wire logic        oneSecondTick,
  output logic             perfUpdate,
  input  wire logic        errInsertSw,
  output logic             errInsert,
  // interrupt pin
  output logic             irqOut_n,
  output logic             irqOe_n
);

  // ****************************************
  // registers
  // ****************************************
  logic [15:0] pinFunc_r;
  logic [15:0] sumEnable_r;
  logic [15:0] refClk_r;
  logic [15:0] glbCtrl_r;
  logic [15:0] regRdData_r;
  logic [7:0]  gpSync1_r;
  logic [7:0]  gpSync2_r;

  wire logic selFunc   = regWr && (regAddr == GPIC_OFF_PIN_FUNC);
  wire logic selEnable = regWr && (regAddr == GPIC_OFF_SUM_ENABLE);
  wire logic selRefClk = regWr && (regAddr == GPIC_OFF_REF_CLK);
  wire logic selGlb    = regWr && (regAddr == GPIC_OFF_GLB_CTRL);

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      pinFunc_r   <= GPIC_RST_PIN_FUNC;
      sumEnable_r <= GPIC_RST_SUM_ENABLE;
      refClk_r    <= GPIC_RST_REF_CLK;
      glbCtrl_r   <= GPIC_RST_GLB_CTRL;
    end
    else
    begin
      if (selFunc)
        pinFunc_r <= regWrData;
      if (selEnable)
        sumEnable_r <= regWrData & GPIC_MSK_SUM;
      if (selRefClk)
        refClk_r <= regWrData & GPIC_MSK_REF_CLK;
      if (selGlb)
        glbCtrl_r <= regWrData & GPIC_MSK_GLB_CTRL;
    end
  end

  // pins are asynchronous to sys_clk
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      gpSync1_r <= 8'h00;
      gpSync2_r <= 8'h00;
    end
    else
    begin
      gpSync1_r <= gpPinIn;
      gpSync2_r <= gpSync1_r;
    end
  end

  // ****************************************
  // control fields
  // ****************************************
  wire logic       ref_output_select   = refClk_r[GPIC_BIT_REF_OUT_SEL];
  wire logic       ref_input_select    = refClk_r[GPIC_BIT_REF_IN_SEL];
  wire logic [3:0] clock_pin_mode      = refClk_r[3:0];
  wire logic       irq_pin_idle_mode   = glbCtrl_r[GPIC_BIT_IRQ_IDLE];
  wire logic       error_insert_source = glbCtrl_r[GPIC_BIT_ERR_SRC];
  wire logic [1:0] perf_update_mode    = glbCtrl_r[GPIC_LSB_PERF_MODE +: 2];

  // ****************************************
  // 8 kHz reference and special inputs
  // ****************************************
  assign global_ref_in = ref_input_select & gpSync2_r[3];

  assign perfUpdate = (perf_update_mode == 2'h0) ? perfUpdateSw :
                      (perf_update_mode == GPIC_PM_PIN8) ? gpSync2_r[7] :
                      oneSecondTick;

  assign errInsert = error_insert_source ? gpSync2_r[5] : errInsertSw;

  // ****************************************
  // general pins
  // ****************************************
  wire logic [7:0] pinOverride;
  wire logic [7:0] pinOvVal;
  wire logic [7:0] pinOvDrive;
  wire logic [7:0] pinStatus;

  assign pinOverride = {perf_update_mode == GPIC_PM_PIN8, 1'b0, error_insert_source,
                        1'b0, ref_input_select, 1'b0, ref_output_select, 1'b0};
  assign pinOvVal    = {6'h00, global_ref_out, 1'b0};
  assign pinOvDrive  = {6'h00, ref_output_select, 1'b0};

  genvar k;
  generate
    for (k = 0; k < 4; k++)
    begin : gPort
      assign pinStatus[2*k]   = portStatusA[k];
      assign pinStatus[2*k+1] = portStatusB[k];
    end
    for (k = 0; k < 8; k++)
    begin : gPin
      gpic_pin_cell uCell (
        .function_sel   (pinFunc_r[2*k +: 2]),
        .override       (pinOverride[k]),
        .override_val   (pinOvVal[k]),
        .override_drive (pinOvDrive[k]),
        .status_sig     (pinStatus[k]),
        .pinOut         (gpPinOut[k]),
        .pinOe_n        (gpPinOe_n[k])
      );
    end
  endgenerate

  // ****************************************
  // rate clock pins
  // ****************************************
  wire gpic_rate_t rateSel  = gpic_rate_t'(clock_pin_mode[3:2]);
  wire logic [1:0] rateCode = clock_pin_mode[1:0];
  wire logic       allIn    = (rateSel == GPIC_RATE_ALL);

  // first and second rates that are not the input rate
  // only an E3 input moves pin B's code 01 rate off E3 onto DS3
  wire logic otherA = (rateSel == GPIC_RATE_E3) ? ds3Clk : e3Clk;
  wire logic otherB = (rateSel == GPIC_RATE_STS1) ? ds3Clk : sts1Clk;

  always_comb
  begin
    rate_clock_pin_b_out = 1'b0;
    rate_clock_pin_c_out = 1'b0;
    unique case (rateCode)
      2'h0:
      begin
        rate_clock_pin_b_out = 1'b0;
        rate_clock_pin_c_out = 1'b0;
      end
      2'h1: rate_clock_pin_b_out = otherA;
      2'h2: rate_clock_pin_c_out = otherB;
      2'h3:
      begin
        rate_clock_pin_b_out = otherB;
        rate_clock_pin_c_out = otherA;
      end
    endcase
  end

  assign rate_clock_pin_b_oe_n = allIn;
  assign rate_clock_pin_c_oe_n = allIn;

  // pin A is the single input in every mode whose rate select bits [3:2] are nonzero
  assign ds3ClkIn  = (allIn || rateSel == GPIC_RATE_DS3) ? rate_clock_pin_a_in : 1'b0;
  assign e3ClkIn   = allIn ? rate_clock_pin_b_in :
                     (rateSel == GPIC_RATE_E3) ? rate_clock_pin_a_in : 1'b0;
  assign sts1ClkIn = allIn ? rate_clock_pin_c_in :
                     (rateSel == GPIC_RATE_STS1) ? rate_clock_pin_a_in : 1'b0;

  // ****************************************
  // interrupt summary
  // ****************************************
  wire logic [15:0] sumStatus;
  assign sumStatus = {8'h00, portIrqPending, 2'h0, txIfacePending,
                      globalLatchedPending};
  wire logic irqActive = |(sumStatus & sumEnable_r);

  assign irqOut_n = ~irqActive;
  assign irqOe_n  = ~(irqActive | irq_pin_idle_mode);

  // ****************************************
  // read path
  // ****************************************
  wire logic [15:0] pinRead;
  assign pinRead = {8'h00, (gpSync2_r & gpPinOe_n) | (gpPinOut & ~gpPinOe_n)};

  wire logic [15:0] rdMux =
    (regAddr == GPIC_OFF_PIN_FUNC)   ? pinFunc_r :
    (regAddr == GPIC_OFF_SUM_STATUS) ? sumStatus :
    (regAddr == GPIC_OFF_SUM_ENABLE) ? sumEnable_r :
    (regAddr == GPIC_OFF_REF_CLK)    ? refClk_r :
    (regAddr == GPIC_OFF_GLB_CTRL)   ? glbCtrl_r :
    (regAddr == GPIC_OFF_PIN_READ)   ? pinRead : 16'h0000;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      regRdData_r <= 16'h0000;
    else if (regRd)
      regRdData_r <= rdMux;
    else
      regRdData_r <= 16'h0000;
  end

  assign regRdData = regRdData_r;

endmodule // gpic_top

/* gpic_board_model.sv */
// board logic model sitting on the general pins and the interrupt pin
`timescale 1ns/1ps
module gpic_board_model
(
  // device side
  input  wire logic [7:0] gpPinOut,
  input  wire logic [7:0] gpPinOe_n,
  input  wire logic       irqOut_n,
  input  wire logic       irqOe_n,
  // board side
  input  wire logic [7:0] boardVal,
  output logic      [7:0] pinLevel,
  output logic            irqLevel_n
);
  // a released pin shows the board's own level, never the last driven one
  assign pinLevel   = (gpPinOut & ~gpPinOe_n) | (boardVal & gpPinOe_n);
  // interrupt line carries a pull-up
  assign irqLevel_n = irqOe_n | irqOut_n;
endmodule // gpic_board_model

/* gpic_top_sva.sv */
// port-level assertions for the global pin and irq control block
`timescale 1ns/1ps
module gpic_top_sva
  import gpic_pkg::*;
(
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_n,
  // register port
  input wire logic [8:0]  regAddr,
  input wire logic [15:0] regWrData,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [15:0] regRdData,
  // pins
  input wire logic [7:0]  gpPinOut,
  input wire logic [7:0]  gpPinOe_n,
  input wire logic        rate_clock_pin_b_out,
  input wire logic        rate_clock_pin_b_oe_n,
  input wire logic        rate_clock_pin_c_oe_n,
  input wire logic        e3Clk,
  input wire logic        global_ref_out,
  input wire logic        global_ref_in,
  // summary sources and interrupt
  input wire logic [3:0]  portIrqPending,
  input wire logic        txIfacePending,
  input wire logic        globalLatchedPending,
  input wire logic        irqOut_n,
  input wire logic        irqOe_n
);
  // shadows rebuilt from bus writes, since registers are not visible here
  logic [15:0] enR;
  logic [15:0] rcR;
  logic [15:0] sumV;
  logic        act;
  assign sumV = {8'h00, portIrqPending, 2'b00, txIfacePending, globalLatchedPending};
  assign act  = |(sumV & enR);
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      enR <= 16'h0000;
      rcR <= 16'h0000;
    end
    else if (regWr)
    begin
      if (regAddr == GPIC_OFF_SUM_ENABLE)
        enR <= regWrData & GPIC_MSK_SUM;
      if (regAddr == GPIC_OFF_REF_CLK)
        rcR <= regWrData;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  irq_active_a: assert property (act |-> !irqOut_n && !irqOe_n)
    else $error("irq not driven low");
  irq_release_a: assert property (!act |-> irqOut_n)
    else $error("irq low while inactive");
  ref_out_a: assert property (rcR[9] |-> !gpPinOe_n[1] && gpPinOut[1] == global_ref_out)
    else $error("pin 2 not carrying reference");
  ref_pin_a: assert property (rcR[8] |-> gpPinOe_n[3])
    else $error("pin 4 driven while reference input");
  ref_low_a: assert property (!rcR[8] |-> !global_ref_in)
    else $error("reference input not low");
  clk_inputs_a: assert property (rcR[3:2] == 2'b00 |-> rate_clock_pin_b_oe_n && rate_clock_pin_c_oe_n)
    else $error("clock pins driven in input mode");
  clk_b_e3_a: assert property (rcR[3:0] == 4'h5 |-> !rate_clock_pin_b_oe_n && rate_clock_pin_b_out == e3Clk)
    else $error("pin B not carrying E3 clock");
  sum_read_a: assert property (regRd && regAddr == GPIC_OFF_SUM_STATUS |=> regRdData == $past(sumV))
    else $error("summary read mismatch");
endmodule // gpic_top_sva

bind gpic_top gpic_top_sva u_gpic_top_sva (.*);

/* gpic_top_tb.sv */
// self-checking testbench for the global pin and irq control block
`timescale 1ns/1ps
module gpic_top_tb;
  import gpic_pkg::*;
  logic sys_clk, rst_n, regWr, regRd, irqOut_n, irqOe_n, irqLevel_n;
  logic [8:0] regAddr;
  logic [15:0] regWrData, regRdData, pf, rc, en, gc, g;
  logic [31:0] rnd;
  logic [7:0] gpPinOut, gpPinOe_n, pinLevel;
  logic rate_clock_pin_b_out, rate_clock_pin_b_oe_n, rate_clock_pin_c_out, rate_clock_pin_c_oe_n;
  logic ds3ClkIn, e3ClkIn, sts1ClkIn, global_ref_in, perfUpdate, errInsert, act;
  int num_errors, samples_checked;
  // rnd packs every random input: pins, status, pending levels, clocks
  gpic_top u_gpic_top (.*, .gpPinIn(pinLevel), .portStatusA(rnd[11:8]), .portStatusB(rnd[15:12]),
    .portIrqPending(rnd[19:16]), .txIfacePending(rnd[20]), .globalLatchedPending(rnd[21]),
    .ds3Clk(rnd[22]), .e3Clk(rnd[23]), .sts1Clk(rnd[24]), .rate_clock_pin_a_in(rnd[25]),
    .rate_clock_pin_b_in(rnd[26]), .rate_clock_pin_c_in(rnd[27]), .global_ref_out(rnd[28]),
    .perfUpdateSw(rnd[29]), .oneSecondTick(rnd[30]), .errInsertSw(rnd[31]));
  gpic_board_model u_gpic_board_model (.*, .boardVal(rnd[7:0]));
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    {regAddr, regWrData, regWr} <= {a, d, 1'b1};
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [8:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    {regAddr, regRd} <= {a, 1'b1};
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 chk(regRdData, e);
  endtask
  function automatic logic [15:0] pinExp(input logic [15:0] f, r2, c1, input logic [31:0] r);
    logic [7:0] v;
    logic [7:0] oe;
    for (int k = 0; k < 8; k++)
    begin
      oe[k] = f[2*k +: 2] == GPIC_FN_INPUT;
      v[k] = f[2*k +: 2] == GPIC_FN_HIGH ||
             (f[2*k +: 2] == GPIC_FN_STATUS && (k[0] ? r[12 + k/2] : r[8 + k/2]));
      if ((k == 3 && r2[8]) || (k == 5 && c1[6]) || (k == 7 && c1[5:4] == GPIC_PM_PIN8))
        oe[k] = 1'b1;
      if (k == 1 && r2[9])
        {oe[k], v[k]} = {1'b0, r[28]};
    end
    return {oe, v & ~oe};
  endfunction
  // {B released, B level, C released, C level}
  function automatic logic [3:0] rateExp(input logic [3:0] m, input logic [31:0] r);
    case (m)
      4'h5, 4'hD: return {1'b0, r[23], 2'b00};
      4'h9:       return {1'b0, r[22], 2'b00};
      4'h6, 4'hA: return {3'b000, r[24]};
      4'hE:       return {3'b000, r[22]};
      4'h7:       return {1'b0, r[24], 1'b0, r[23]};
      4'hB:       return {1'b0, r[24], 1'b0, r[22]};
      4'hF:       return {1'b0, r[22], 1'b0, r[23]};
      default:    return (m[3:2] == 2'b00) ? 4'hA : 4'h0;
    endcase
  endfunction
  task automatic complete_run;
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    num_errors++;
    complete_run;
  end
  initial
  begin
    {rst_n, regWr, regRd, regAddr, regWrData} = '0;
    rnd = $urandom(70919);
    num_errors = 0;
    samples_checked = 0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(GPIC_OFF_PIN_FUNC, GPIC_RST_PIN_FUNC);
    rd(GPIC_OFF_SUM_ENABLE, GPIC_RST_SUM_ENABLE);
    chk({8'h00, gpPinOe_n}, 16'h00FF);
    rd(9'h1FE, 16'h0000);
    for (int i = 0; i < 80; i++)
    begin
      {pf, rc, en, gc} = {$urandom, $urandom};
      // first pass sweeps every clock pin mode
      if (i < 16)
        rc[3:0] = i[3:0];
      @(posedge sys_clk);
      rnd <= $urandom;
      wr(GPIC_OFF_PIN_FUNC, pf);
      wr(GPIC_OFF_REF_CLK, rc);
      wr(GPIC_OFF_SUM_ENABLE, en);
      wr(GPIC_OFF_GLB_CTRL, gc);
      wr(GPIC_OFF_SUM_STATUS, 16'hFFFF);
      rd(GPIC_OFF_PIN_FUNC, pf);
      rd(GPIC_OFF_SUM_ENABLE, en & GPIC_MSK_SUM);
      rd(GPIC_OFF_SUM_STATUS, {8'h00, rnd[19:16], 2'b00, rnd[20], rnd[21]});
      chk({gpPinOe_n, gpPinOut & ~gpPinOe_n}, pinExp(pf, rc, gc, rnd));
      g = {rate_clock_pin_b_oe_n, rate_clock_pin_b_out & ~rate_clock_pin_b_oe_n,
           rate_clock_pin_c_oe_n, rate_clock_pin_c_out & ~rate_clock_pin_c_oe_n};
      chk(g, {12'h000, rateExp(rc[3:0], rnd)});
      act = |({rnd[19:16], 2'b00, rnd[20], rnd[21]} & en[7:0]);
      g = {global_ref_in, perfUpdate, errInsert, irqOut_n, irqOe_n, irqLevel_n};
      chk(g, {rc[8] & rnd[3], gc[5] ? rnd[30] : (gc[4] ? rnd[7] : rnd[29]),
              gc[6] ? rnd[5] : rnd[31], !act, !(act | gc[14]), !act});
    end
    complete_run;
  end
endmodule // gpic_top_tb
